/* core/omc_top.sv */
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
// Contract
// - host commands arrive as 16-bit frames
// - power-up and soft reset enter init
// - start in init; long window after release
// - stop mode keeps main regulator on
// - sleep mode turns buck off
// - wake, or watchdog failure in restart configs, enters restart, resets
// - restart leaves to normal after reset delay
// - thermal shutdown two enters fail-safe, buck off
// - development mode stops watchdog counter
// - grounded fail/test pin selects development mode
// - host writes mode select field
// - restart clears mode select field
// - io config pin latched until power-on reset
// - open pin: aux off, host sets, 5V supervision
// - grounded pin: aux 3.3V follows main
// - interrupt pin plus count bit give config
// - restart configs: fail output after 1st/2nd
// - pull interrupt pin low, sample at release
// - fail-safe configs: watchdog failure enters fail-safe; with the count bit clear the first failure enters restart
// - any command in init after release goes normal
module omc_top #(
  parameter int unsigned LONG_WINDOW_CYCLES = omc_pkg::LW_CYCLES
) (
  input  wire logic                 ref_clk_in,
  input  wire logic                 reset_in,
  input  wire logic [omc_pkg::AW-1:0] addr_in,
  input  wire logic [omc_pkg::DW-1:0] wdata_in,
  input  wire logic                 wr_in,
  input  wire logic                 rd_in,
  output logic      [omc_pkg::DW-1:0] rdata_out,
  input  wire logic                 io_supply_config_pin_in,
  input  wire logic                 fail_test_pin_in,
  input  wire logic                 interrupt_out_pin_in,
  output logic                      interrupt_out_pin_out,
  output logic                      interrupt_out_pin_oe_n_out,
  input  wire logic                 wake_event_in,
  input  wire logic                 thermal_shutdown_level_two_in,
  input  wire logic                 failure_cond_in,
  output logic                      reset_out_pin_n_out,
  output logic                      fail_output_pin_out,
  output logic                      main_supply_en_out,
  output logic                      aux_supply_en_out,
  output logic      [1:0]           aux_voltage_select_out,
  output logic                      aux_fixed_3v3_out,
  output logic                      supervision_3v3_out,
  output logic                      uv_flag_to_main_out,
  output logic                      watchdog_running_out,
  output logic                      dev_mode_out,
  output logic      [2:0]           mode_out
);
  import omc_pkg::*;

  omc_tmr_if rd_t ();
  omc_tmr_if wd_t ();

  omc_timer u_rd_timer (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .t          (rd_t)
  );
  omc_timer u_wd_timer (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .t          (wd_t)
  );

  omc_state_e      state_q;
  omc_state_e      state_d;
  logic            pwr_start_q;
  logic            rst_rel_q;
  logic            rst_rel_d;
  logic            rd_elapsed_q;
  logic            rd_elapsed_d;
  logic            cfg_done_q;
  logic            cfg1_q;
  logic            dev_q;
  logic            io_cfg_q;
  logic [1:0]      mode_sel_q;
  logic [1:0]      mode_sel_d;
  logic [1:0]      aux_vsel_q;
  logic            aux_en_q;
  logic            fcnt_sel_q;
  logic            fo_test_q;
  logic [1:0]      wd_fail_cnt_q;
  logic [1:0]      wd_fail_cnt_d;
  logic            fo_q;
  logic            fo_d;
  logic [DW-1:0]   rdata_q;
  logic [DW-1:0]   rdata_d;
  logic            int_oe_n_q;
  logic            main_en_q;
  logic            aux_en_out_q;
  logic [1:0]      aux_vsel_out_q;
  logic            wd_run_q;
  logic [2:0]      mode_out_q;
  logic            fo_pin_q;
  logic            aux_fix_q;

  // register decode
  wire             any_cmd      = wr_in || rd_in;
  wire             hit_mode     = addr_in == ADDR_MODE_CTRL;
  wire             hit_hw       = addr_in == ADDR_HW_CTRL;
  wire             hit_wd       = addr_in == ADDR_WD_TRIG;
  wire             hit_status   = addr_in == ADDR_STATUS;
  wire [1:0]       sel_wr       = wdata_in[MODE_SEL_LSB +: 2];
  wire             in_init      = state_q == OMC_INIT;
  wire             in_normal    = state_q == OMC_NORMAL;
  wire             in_stop      = state_q == OMC_STOP;
  // stop mode accepts only mode changes and triggers; sleep ignores all writes
  wire             cfg_wr_ok    = in_init || in_normal;
  wire             mode_wr      = wr_in && hit_mode && (cfg_wr_ok || in_stop);
  wire             hw_wr        = wr_in && hit_hw && cfg_wr_ok;
  wire             wd_trig      = wr_in && hit_wd && (cfg_wr_ok || in_stop);

  // watchdog
  wire             wd_active    = rst_rel_q && !dev_q &&
                                  (in_init || in_normal || in_stop);
  wire             wd_fail      = wd_t.expired && wd_active;
  wire             restart_type = cfg1_q;
  wire [1:0]       fo_need      = fcnt_sel_q ? 2'h1 : 2'h2;
  // second-failure fail-safe config still takes the first failure through restart
  wire             wd_to_restart = restart_type || (!fcnt_sel_q && wd_fail_cnt_q == 2'h0);

  // reset delay
  wire             rd_done      = rd_elapsed_q || rd_t.expired;
  wire             enter_delay  = pwr_start_q ||
                                  (state_d != state_q &&
                                   (state_d == OMC_INIT || state_d == OMC_RESTART));
  wire             rel_edge     = !rst_rel_q && rst_rel_d;

  // next state
  always_comb begin
    state_d = state_q;
    if (thermal_shutdown_level_two_in) begin
      state_d = OMC_FAILSAFE;
    end else if (wd_fail) begin
      state_d = wd_to_restart ? OMC_RESTART : OMC_FAILSAFE;
    end else begin
      unique case (state_q)
        OMC_INIT: begin
          if (rst_rel_q && any_cmd) state_d = OMC_NORMAL;
        end
        OMC_NORMAL: begin
          if (mode_wr) begin
            unique case (omc_sel_e'(sel_wr))
              OMC_SEL_SLEEP:   state_d = OMC_SLEEP;
              OMC_SEL_STOP:    state_d = OMC_STOP;
              OMC_SEL_SOFTRST: state_d = OMC_INIT;
              OMC_SEL_NORMAL:  state_d = OMC_NORMAL;
            endcase
          end
        end
        OMC_STOP: begin
          if (mode_wr) begin
            unique case (omc_sel_e'(sel_wr))
              OMC_SEL_SLEEP:   state_d = OMC_RESTART;
              OMC_SEL_STOP:    state_d = OMC_STOP;
              OMC_SEL_SOFTRST: state_d = OMC_INIT;
              OMC_SEL_NORMAL:  state_d = OMC_NORMAL;
            endcase
          end
        end
        OMC_SLEEP: begin
          if (wake_event_in) state_d = OMC_RESTART;
        end
        OMC_RESTART: begin
          if (rd_done && !failure_cond_in) state_d = OMC_NORMAL;
        end
        OMC_FAILSAFE: begin
          if (wake_event_in) state_d = OMC_RESTART;
        end
        default: state_d = OMC_INIT;
      endcase
    end
  end

  // reset output: low through init delay and all of restart
  always_comb begin
    rst_rel_d = rst_rel_q;
    if (enter_delay) begin
      rst_rel_d = 1'b0;
    end else if (state_q == OMC_INIT && rd_done) begin
      rst_rel_d = 1'b1;
    end else if (state_q == OMC_RESTART && state_d == OMC_NORMAL) begin
      rst_rel_d = 1'b1;
    end
  end

  assign rd_elapsed_d = enter_delay ? 1'b0 : rd_done;
  assign rd_t.load     = enter_delay;
  assign rd_t.load_val = TMR_W'(RD_CYCLES);
  assign rd_t.run      = 1'b1;

  // long open window restarts on release and on every trigger
  assign wd_t.load     = rel_edge || wd_trig;
  assign wd_t.load_val = TMR_W'(LONG_WINDOW_CYCLES);
  assign wd_t.run      = wd_active;

  assign mode_sel_d = (state_d == OMC_RESTART || state_d == OMC_INIT) ? MODE_CTRL_RST
                    : mode_wr ? sel_wr : mode_sel_q;
  assign wd_fail_cnt_d = (wd_fail && wd_fail_cnt_q != 2'h3) ? wd_fail_cnt_q + 2'h1
                       : wd_fail_cnt_q;
  assign fo_d = fo_q || (wd_fail && wd_fail_cnt_d >= fo_need);

  // status word
  wire [DW-1:0] status_w = {6'h00, wd_fail_cnt_q, fo_q, io_cfg_q, dev_q,
                            fcnt_sel_q, cfg1_q, 3'(state_q)};
  wire [DW-1:0] mode_w   = {10'h000, aux_en_q, aux_vsel_q, 1'b0, mode_sel_q};
  wire [DW-1:0] hw_w     = {14'h0000, fo_test_q, fcnt_sel_q};
  assign rdata_d = !rd_in    ? '0
                 : hit_mode   ? mode_w
                 : hit_hw     ? hw_w
                 : hit_status ? status_w
                 : '0;

  // supply steering
  wire main_en_d = !(state_d == OMC_SLEEP || state_d == OMC_FAILSAFE);
  wire aux_en_d  = io_cfg_q ? aux_en_q : main_en_d;

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q      <= OMC_INIT;
      pwr_start_q  <= 1'b1;
      rst_rel_q    <= 1'b0;
      rd_elapsed_q <= 1'b0;
      mode_sel_q   <= MODE_CTRL_RST;
      wd_fail_cnt_q <= 2'h0;
      fo_q         <= 1'b0;
      rdata_q      <= '0;
    end else begin
      state_q      <= state_d;
      pwr_start_q  <= 1'b0;
      rst_rel_q    <= rst_rel_d;
      rd_elapsed_q <= rd_elapsed_d;
      mode_sel_q   <= mode_sel_d;
      wd_fail_cnt_q <= wd_fail_cnt_d;
      fo_q         <= fo_d;
      rdata_q      <= rdata_d;
    end
  end

  // straps: io config caught by the first clock after reset, the other two at the first release; never by the async reset itself
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cfg_done_q <= 1'b0;
      cfg1_q     <= 1'b0;
      dev_q      <= 1'b0;
      io_cfg_q   <= 1'b1;
    end else begin
      if (pwr_start_q) io_cfg_q <= io_supply_config_pin_in;
      if (rel_edge && !cfg_done_q) begin
        cfg_done_q <= 1'b1;
        cfg1_q     <= interrupt_out_pin_in;
        dev_q      <= !fail_test_pin_in;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      aux_vsel_q <= AUX_VSEL_RST;
      aux_en_q   <= AUX_EN_RST;
      fcnt_sel_q <= FCNT_SEL_RST;
      fo_test_q  <= 1'b0;
    end else begin
      if (mode_wr && cfg_wr_ok) begin
        aux_vsel_q <= wdata_in[AUX_VSEL_LSB +: 2];
        aux_en_q   <= wdata_in[AUX_EN_BIT];
      end
      if (hw_wr) begin
        fcnt_sel_q <= wdata_in[FCNT_SEL_BIT];
        fo_test_q  <= wdata_in[FO_TEST_BIT];
      end
      if (!in_normal) fo_test_q <= 1'b0;
    end
  end

  // output flops; mode and main supply enable load from state_d, so they track state_q without lag
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      int_oe_n_q     <= 1'b0;
      main_en_q      <= 1'b1;
      aux_en_out_q   <= 1'b0;
      aux_vsel_out_q <= 2'h0;
      wd_run_q       <= 1'b0;
      mode_out_q     <= 3'h0;
      fo_pin_q       <= 1'b0;
      aux_fix_q      <= 1'b0;
    end else begin
      int_oe_n_q     <= cfg_done_q || rel_edge;
      main_en_q      <= main_en_d;
      aux_en_out_q   <= aux_en_d;
      aux_vsel_out_q <= io_cfg_q ? aux_vsel_q : 2'h0;
      wd_run_q       <= wd_t.run;
      mode_out_q     <= 3'(state_d);
      // registered so the pin never glitches when latch and test bit change together
      fo_pin_q       <= fo_q || fo_test_q;
      aux_fix_q      <= !io_cfg_q;
    end
  end

  assign rdata_out                  = rdata_q;
  assign interrupt_out_pin_out      = 1'b0;
  assign interrupt_out_pin_oe_n_out = int_oe_n_q;
  assign reset_out_pin_n_out        = rst_rel_q;
  assign fail_output_pin_out        = fo_pin_q;
  assign main_supply_en_out         = main_en_q;
  assign aux_supply_en_out          = aux_en_out_q;
  assign aux_voltage_select_out     = aux_vsel_out_q;
  assign aux_fixed_3v3_out          = aux_fix_q;
  assign supervision_3v3_out        = aux_fix_q;
  assign uv_flag_to_main_out        = aux_fix_q;
  assign watchdog_running_out       = wd_run_q;
  assign dev_mode_out               = dev_q;
  assign mode_out                   = mode_out_q;
endmodule : omc_top

/* core/omc_pkg.sv */
package omc_pkg;
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned LW_TIME_MS      = 200;
  localparam int unsigned LW_CYCLES       = LW_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned RD_TIME_US      = 10;
  localparam int unsigned RD_CYCLES       = RD_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned TMR_W           = 23;
  localparam int unsigned AW              = 8;
  localparam int unsigned DW              = 16;

  localparam logic [7:0]  ADDR_MODE_CTRL  = 8'h00;
  localparam logic [7:0]  ADDR_HW_CTRL    = 8'h04;
  localparam logic [7:0]  ADDR_WD_TRIG    = 8'h08;
  localparam logic [7:0]  ADDR_STATUS     = 8'h0C;

  localparam int unsigned MODE_SEL_LSB    = 0;
  localparam int unsigned AUX_VSEL_LSB    = 3;
  localparam int unsigned AUX_EN_BIT      = 5;
  localparam int unsigned FCNT_SEL_BIT    = 0;
  localparam int unsigned FO_TEST_BIT     = 1;

  localparam logic [1:0]  MODE_CTRL_RST   = 2'h0;
  localparam logic [1:0]  AUX_VSEL_RST    = 2'h0;
  localparam logic        AUX_EN_RST      = 1'b0;
  localparam logic        FCNT_SEL_RST    = 1'b0;

  typedef enum logic [1:0] {
    OMC_SEL_NORMAL = 2'b00,
    OMC_SEL_SLEEP  = 2'b01,
    OMC_SEL_STOP   = 2'b10,
    OMC_SEL_SOFTRST = 2'b11
  } omc_sel_e;

  typedef enum logic [2:0] {
    OMC_INIT     = 3'b000,
    OMC_NORMAL   = 3'b001,
    OMC_STOP     = 3'b010,
    OMC_SLEEP    = 3'b011,
    OMC_RESTART  = 3'b100,
    OMC_FAILSAFE = 3'b101
  } omc_state_e;
endpackage : omc_pkg

/* core/omc_tmr_if.sv */
`timescale 1ns/1ps
interface omc_tmr_if;
  import omc_pkg::*;
  logic             load;
  logic [TMR_W-1:0] load_val;
  logic             run;
  logic             expired;
  modport ctl (output load, output load_val, output run, input expired);
  modport tmr (input load, input load_val, input run, output expired);
endinterface : omc_tmr_if

/* core/omc_timer.sv */
`timescale 1ns/1ps
module omc_timer (
  input  wire logic ref_clk_in,
  input  wire logic reset_in,
  omc_tmr_if.tmr    t
);
  import omc_pkg::*;
  logic [TMR_W-1:0] count_q;
  logic [TMR_W-1:0] count_d;
  // expiry is one pulse; the counter then parks at zero until reloaded
  assign t.expired = t.run && (count_q == TMR_W'(1));
  assign count_d   = t.load ? t.load_val
                   : (t.run && count_q != '0) ? count_q - TMR_W'(1) : count_q;
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) count_q <= '0;
    else          count_q <= count_d;
  end
endmodule : omc_timer

/* test/omc_mcu_model.sv */
`timescale 1ns/1ps
module omc_mcu_model #(
  parameter bit PULL_UP = 1'b1
) (
  input  wire logic pin_drv_in,
  input  wire logic pin_oe_n_in,
  input  wire logic test_gnd_in,
  output logic      int_pin_out,
  output logic      test_pin_out
);
  // an external pull-up overpowers the weak pull-down; an open released pin reads high
  assign int_pin_out  = PULL_UP || pin_oe_n_in || pin_drv_in;
  // strap only changes while the bench holds the supply reset
  assign test_pin_out = !test_gnd_in;
endmodule : omc_mcu_model

/* test/omc_properties.sv */
`timescale 1ns/1ps
module omc_checker (
  input wire logic                     ref_clk_in,
  input wire logic                     reset_in,
  input wire logic                     rd_in,
  input wire logic [omc_pkg::DW-1:0]   rdata_out,
  input wire logic                     thermal_shutdown_level_two_in,
  input wire logic                     interrupt_out_pin_out,
  input wire logic                     interrupt_out_pin_oe_n_out,
  input wire logic                     reset_out_pin_n_out,
  input wire logic                     main_supply_en_out,
  input wire logic                     aux_supply_en_out,
  input wire logic [1:0]               aux_voltage_select_out,
  input wire logic                     aux_fixed_3v3_out,
  input wire logic                     supervision_3v3_out,
  input wire logic                     uv_flag_to_main_out,
  input wire logic                     watchdog_running_out,
  input wire logic                     dev_mode_out,
  input wire logic [2:0]               mode_out
);
  import omc_pkg::*;
  logic [15:0] rst_cnt_q;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // counts cycles spent in restart so the exit can be tied to the delay
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) rst_cnt_q <= 16'h0000;
    else rst_cnt_q <= (mode_out == OMC_RESTART) ? rst_cnt_q + 16'h0001 : 16'h0000;
  end
  rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
    else $error("read data outside its cycle");
  stop_main_a: assert property (mode_out == OMC_STOP |-> main_supply_en_out)
    else $error("main supply off in stop");
  sleep_buck_a: assert property (mode_out == OMC_SLEEP |-> !main_supply_en_out)
    else $error("main supply on in sleep");
  restart_reset_a: assert property ($rose(mode_out == OMC_RESTART)
    |-> ##[0:1] !reset_out_pin_n_out)
    else $error("restart without reset");
  restart_delay_a: assert property ($past(mode_out) == OMC_RESTART
    && mode_out == OMC_NORMAL |-> $past(rst_cnt_q) >= 16'(RD_CYCLES - 1))
    else $error("restart left too early");
  thermal_fs_a: assert property (thermal_shutdown_level_two_in
    |-> ##[1:3] (mode_out == OMC_FAILSAFE) ##1 !main_supply_en_out)
    else $error("thermal shutdown not fail-safe");
  dev_wd_a: assert property (dev_mode_out |-> !watchdog_running_out)
    else $error("watchdog runs in development mode");
  cfg_stable_a: assert property (reset_out_pin_n_out |-> $stable(aux_fixed_3v3_out))
    else $error("io config changed");
  superv_a: assert property (supervision_3v3_out == aux_fixed_3v3_out
    && uv_flag_to_main_out == aux_fixed_3v3_out)
    else $error("supervision level mismatch");
  aux_follow_a: assert property (aux_fixed_3v3_out
    |-> aux_supply_en_out == main_supply_en_out && aux_voltage_select_out == 2'h0)
    else $error("fixed aux output not following main");
  pull_low_a: assert property ($rose(interrupt_out_pin_oe_n_out)
    |-> reset_out_pin_n_out && !interrupt_out_pin_out)
    else $error("interrupt pin released early");
endmodule : omc_checker
bind omc_top omc_checker chk_i (
  .ref_clk_in                    (ref_clk_in),
  .reset_in                      (reset_in),
  .rd_in                         (rd_in),
  .rdata_out                     (rdata_out),
  .thermal_shutdown_level_two_in (thermal_shutdown_level_two_in),
  .interrupt_out_pin_out         (interrupt_out_pin_out),
  .interrupt_out_pin_oe_n_out    (interrupt_out_pin_oe_n_out),
  .reset_out_pin_n_out           (reset_out_pin_n_out),
  .main_supply_en_out            (main_supply_en_out),
  .aux_supply_en_out             (aux_supply_en_out),
  .aux_voltage_select_out        (aux_voltage_select_out),
  .aux_fixed_3v3_out             (aux_fixed_3v3_out),
  .supervision_3v3_out           (supervision_3v3_out),
  .uv_flag_to_main_out           (uv_flag_to_main_out),
  .watchdog_running_out          (watchdog_running_out),
  .dev_mode_out                  (dev_mode_out),
  .mode_out                      (mode_out)
);

/* test/tb.sv */
`timescale 1ns/1ps
module tb;
  import omc_pkg::*;
  logic ref_clk_in = 1'b0, reset_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
  logic [AW-1:0] addr_in = 8'h00;
  logic [DW-1:0] wdata_in = 16'h0000, rdata_out, v;
  logic wake_in = 1'b0, therm_in = 1'b0, fcond_in = 1'b0, int_pin, test_pin;
  logic io_pin = 1'b1, test_gnd = 1'b0;
  logic int_drv, int_oe_n, rst_n, fo, main_en, aux_en, fix3, sup3, uvm, wdr, dev;
  logic [1:0] avs;
  logic [2:0] mode_out;
  int bad_count = 0, comparisons = 0, cycles = 0;
  omc_top #(.LONG_WINDOW_CYCLES(3000)) dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .io_supply_config_pin_in(io_pin), .fail_test_pin_in(test_pin),
    .interrupt_out_pin_in(int_pin), .interrupt_out_pin_out(int_drv),
    .interrupt_out_pin_oe_n_out(int_oe_n), .wake_event_in(wake_in),
    .thermal_shutdown_level_two_in(therm_in), .failure_cond_in(fcond_in),
    .reset_out_pin_n_out(rst_n), .fail_output_pin_out(fo), .main_supply_en_out(main_en),
    .aux_supply_en_out(aux_en), .aux_voltage_select_out(avs), .aux_fixed_3v3_out(fix3),
    .supervision_3v3_out(sup3), .uv_flag_to_main_out(uvm), .watchdog_running_out(wdr),
    .dev_mode_out(dev), .mode_out(mode_out));
  omc_mcu_model mcu (.pin_drv_in(int_drv), .pin_oe_n_in(int_oe_n), .test_gnd_in(test_gnd),
    .int_pin_out(int_pin), .test_pin_out(test_pin));
  initial begin
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  task automatic summarize;
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask : rd
  // bounded wait: a stuck state machine shows up as a mismatch, not a hang
  task automatic wait_mode(input logic [2:0] m, input int bound);
    for (int n = 0; n < bound && mode_out !== m; n++) step(1);
    chk({13'h0000, mode_out}, {13'h0000, m});
  endtask : wait_mode
  task automatic wait_release;
    for (int n = 0; n < 400 && rst_n !== 1'b1; n++) step(1);
    chk({15'h0000, rst_n}, 16'h0001);
  endtask : wait_release
  initial begin
    step(12);
    reset_in <= 1'b0;
    chk({13'h0000, mode_out}, 16'h0000);
    wait_release();
    rd(ADDR_STATUS, v);
    chk(v & 16'h0078, 16'h0048);
    wait_mode(OMC_NORMAL, 4);
    chk({15'h0000, wdr}, 16'h0001);
    wr(ADDR_MODE_CTRL, 16'h0030);
    step(2);
    chk({13'h0000, fix3, aux_en, avs}, 16'h0006);
    wr(ADDR_MODE_CTRL, 16'h0032);
    wait_mode(OMC_STOP, 4);
    step(1);
    chk({15'h0000, main_en}, 16'h0001);
    fcond_in <= 1'b1;
    wr(ADDR_MODE_CTRL, 16'h0001);
    wait_mode(OMC_RESTART, 4);
    step(300);
    chk({13'h0000, mode_out}, {13'h0000, OMC_RESTART});
    fcond_in <= 1'b0;
    wait_mode(OMC_NORMAL, 10);
    chk({15'h0000, rst_n}, 16'h0001);
    rd(ADDR_MODE_CTRL, v);
    chk(v & 16'h0003, 16'h0000);
    wr(ADDR_MODE_CTRL, 16'h0001);
    wait_mode(OMC_SLEEP, 4);
    step(1);
    chk({15'h0000, main_en}, 16'h0000);
    wake_in <= 1'b1;
    wait_mode(OMC_RESTART, 4);
    wake_in <= 1'b0;
    step(2);
    chk({15'h0000, rst_n}, 16'h0000);
    wait_mode(OMC_NORMAL, 300);
    therm_in <= 1'b1;
    wait_mode(OMC_FAILSAFE, 4);
    step(1);
    chk({15'h0000, main_en}, 16'h0000);
    therm_in <= 1'b0;
    step(2);
    wake_in <= 1'b1;
    wait_mode(OMC_RESTART, 4);
    wake_in <= 1'b0;
    wait_mode(OMC_NORMAL, 300);
    wr(ADDR_MODE_CTRL, 16'h0003);
    wait_mode(OMC_INIT, 4);
    step(2);
    chk({15'h0000, rst_n}, 16'h0000);
    wait_release();
    wr(ADDR_WD_TRIG, 16'h0001);
    wait_mode(OMC_NORMAL, 4);
    wr(ADDR_HW_CTRL, 16'h0003);
    step(2);
    chk({15'h0000, fo}, 16'h0001);
    wr(ADDR_HW_CTRL, 16'h0001);
    step(2);
    chk({15'h0000, fo}, 16'h0000);
    // no more triggers: the long window runs out and counts one failure
    wait_mode(OMC_RESTART, 3200);
    step(2);
    chk({15'h0000, fo}, 16'h0001);
    rd(ADDR_STATUS, v);
    chk(v & 16'h0390, 16'h0190);
    // second power-up with both straps grounded: fixed aux level and debug mode
    reset_in <= 1'b1;
    io_pin <= 1'b0;
    test_gnd <= 1'b1;
    step(3);
    reset_in <= 1'b0;
    wait_release();
    rd(ADDR_STATUS, v);
    chk(v & 16'h0078, 16'h0028);
    chk({13'h0000, fix3, aux_en, avs}, 16'h000C);
    chk({14'h0000, dev, wdr}, 16'h0002);
    wait_mode(OMC_NORMAL, 4);
    // the 3000-cycle window would have run out shortly before this check if the watchdog still counted
    step(3100);
    chk({13'h0000, mode_out}, {13'h0000, OMC_NORMAL});
    summarize();
  end
endmodule : tb
